// [psc_sram.sv]
// Function
// - Memory port acts on clock edges only while the clock qualifier is low; strap, test port and bus act on every edge.
// - Qualifier high stretches the current cycle; it never deselects.
// - Write data on the data lines is captured into a data register.
// - Read data appears one cycle after its address was captured.
// - Data lines drive only when the last qualified clock edge sampled the output-drive enable low.
// - Tristate during write data phase, first clock after deselect, deselected.
// - Parity lanes behave as data; written only with their byte select.
// - Strap high gives interleaved burst order, low gives linear.
// - Strap is sampled once after reset; the interleaved reset value holds only until then.
// - Test serial output changes on the falling test-clock edge.
// - Test serial input is sampled on the rising test-clock edge.
// - Mode-select is sampled on rising test-clock edges to step the TAP.
// - Sleep request gives a quiet state and keeps memory contents.
// - Sleep input reads low when grounded or left open.
// - Advance/load high advances burst counter, low loads an address.
`timescale 1ns/10ps
`default_nettype none
module psc_sram #(
    parameter int ADDR_W = 19,
    parameter int LANES  = 4
) (
    input  wire logic              i_sys_clk,           // 10 MHz
    input  wire logic              i_rst_n,             // Sync reset
    input  wire logic              i_clock_qualifier_n, // Low: act
    input  wire logic [ADDR_W-1:0] i_addr,              // Address
    input  wire psc_pkg::psc_ctl_t i_ctl,               // Controls
    input  wire logic [LANES-1:0]  i_byte_write_select_n, // Lanes
    input  wire logic [8*LANES-1:0] i_dq,               // Data in
    input  wire logic [LANES-1:0]  i_parity_io_lines,   // Parity in
    output logic      [8*LANES-1:0] o_dq,               // Data out
    output logic      [LANES-1:0]  o_parity_io_lines,   // Parity out
    output logic                   o_io_oe,             // Drive enable
    input  wire logic              i_output_drive_n,    // Low: drive
    input  wire logic              i_burst_order_strap, // High: intlv
    input  wire logic              i_sleep_request,     // High: sleep
    input  wire logic              i_tck,               // Test clock
    input  wire logic              i_tms,               // Mode select
    input  wire logic              i_tdi,               // Serial in
    output logic                   o_tdo,               // Serial out
    input  wire logic              i_axi_awvalid,       // AW valid
    output logic                   o_axi_awready,       // AW ready
    input  wire logic [7:0]        i_axi_awaddr,        // AW address
    input  wire logic              i_axi_wvalid,        // W valid
    output logic                   o_axi_wready,        // W ready
    input  wire logic [31:0]       i_axi_wdata,         // W data
    input  wire logic [3:0]        i_axi_wstrb,         // W strobes
    output logic                   o_axi_bvalid,        // B valid
    input  wire logic              i_axi_bready,        // B ready
    output logic [1:0]             o_axi_bresp,         // B resp
    input  wire logic              i_axi_arvalid,       // AR valid
    output logic                   o_axi_arready,       // AR ready
    input  wire logic [7:0]        i_axi_araddr,        // AR address
    output logic                   o_axi_rvalid,        // R valid
    input  wire logic              i_axi_rready,        // R ready
    output logic [31:0]            o_axi_rdata,         // R data
    output logic [1:0]             o_axi_rresp          // R resp
);
    localparam int WW = psc_pkg::LANE_W * LANES;

    if (ADDR_W < 2 || ADDR_W > 24 || LANES < 1 || LANES > 4) begin : g_bad
        $error("psc_sram: unsupported ADDR_W or LANES");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              s1_vld;
        logic              s1_wr;
        logic [ADDR_W-1:0] s1_addr;
        logic [LANES-1:0]  s1_bw_n;
        logic [1:0]        base;
        logic [1:0]        cnt;
        logic              wr_vld;
        logic [ADDR_W-1:0] wr_addr;
        logic [LANES-1:0]  wr_bw_n;
        logic              cm_vld;
        logic [ADDR_W-1:0] cm_addr;
        logic [LANES-1:0]  cm_bw_n;
        logic [WW-1:0]     din;
        logic [WW-1:0]     dout;
        logic              io_oe;
        logic              mode;
        logic              strap_done;
        logic              tck_prev;
        psc_pkg::psc_tap_t tap;
        logic              bypass;
        logic              tdo;
        logic              force_sleep;
        logic              awready;
        logic              wready;
        logic              aw_got;
        logic              w_got;
        logic [7:0]        waddr;
        logic [31:0]       wdata;
        logic              ctrl_we;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } psc_state_t;

    localparam psc_state_t ST_RST = '{
        mode: psc_pkg::MODE_RST, tap: psc_pkg::TAP_RESET,
        awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    psc_state_t    st_q;
    psc_state_t    st_d;
    logic [WW-1:0] rd_word;
    logic [WW-1:0] pin_word;
    logic          qual;
    logic          sleep;
    logic          t_rise;
    logic          t_fall;

    // ------------------------------------------------------------
    // Storage, one array per byte lane with its parity bit
    // ------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [8:0] mem [2**ADDR_W];
        always_ff @(posedge i_sys_clk) begin
            // Write mask per lane covers parity too; no reset of data
            if (qual && st_q.cm_vld && !st_q.cm_bw_n[g]) begin
                mem[st_q.cm_addr] <= st_q.din[g*9 +: 9];
            end
        end
        assign rd_word[g*9 +: 9]  = mem[st_q.s1_addr];
        assign pin_word[g*9 +: 9] = {i_parity_io_lines[g],
                                     i_dq[g*8 +: 8]};
        assign o_dq[g*8 +: 8]       = st_q.dout[g*9 +: 8];
        assign o_parity_io_lines[g] = st_q.dout[g*9+8];
    end

    assign qual   = ~i_clock_qualifier_n;
    // Pad pull-down lives outside; an open pin arrives here as low
    assign sleep  = i_sleep_request | st_q.force_sleep;
    assign t_rise = i_tck & ~st_q.tck_prev;
    assign t_fall = ~i_tck & st_q.tck_prev;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       sel;
        logic [1:0] nc;
        logic [7:0] ra;
        sel  = ~i_ctl.chip_select_1_n & i_ctl.chip_select_2
             & ~i_ctl.chip_select_3_n;
        nc   = st_q.cnt + 2'h1;
        ra   = i_axi_araddr;
        st_d = st_q;

        // Strap caught once after reset; it replaces the interleaved reset default
        if (!st_q.strap_done) begin
            st_d.mode       = i_burst_order_strap;
            st_d.strap_done = 1'b1;
        end

        if (qual) begin
            st_d.wr_vld  = st_q.s1_vld & st_q.s1_wr;
            st_d.wr_addr = st_q.s1_addr;
            st_d.wr_bw_n = st_q.s1_bw_n;
            st_d.cm_vld  = st_q.wr_vld;
            st_d.cm_addr = st_q.wr_addr;
            st_d.cm_bw_n = st_q.wr_bw_n;
            st_d.din     = pin_word;
            st_d.dout    = rd_word;
            // Only a read data phase drives; deselect, write data
            // phase and the clock after deselect all stay quiet
            st_d.io_oe   = ~i_output_drive_n & st_q.s1_vld
                         & ~st_q.s1_wr & ~sleep;
            if (sleep) begin
                st_d.s1_vld = 1'b0;
            end else if (i_ctl.advance_or_load) begin
                st_d.cnt     = nc;
                st_d.s1_bw_n = i_byte_write_select_n;
                st_d.s1_addr[1:0] = st_q.mode ? (st_q.base ^ nc)
                                              : (st_q.base + nc);
            end else begin
                st_d.s1_vld  = sel;
                st_d.s1_wr   = ~i_ctl.write_select_n;
                st_d.s1_addr = i_addr;
                st_d.s1_bw_n = i_byte_write_select_n;
                st_d.base    = i_addr[1:0];
                st_d.cnt     = 2'h0;
            end
        end

        // Test port, test clock sampled as a plain input
        st_d.tck_prev = i_tck;
        if (t_rise) begin
            if (st_q.tap == psc_pkg::TAP_SHFDR ||
                st_q.tap == psc_pkg::TAP_SHFIR) begin
                st_d.bypass = i_tdi;
            end
            unique case (st_q.tap)
                psc_pkg::TAP_RESET: st_d.tap = i_tms ? psc_pkg::TAP_RESET
                                                     : psc_pkg::TAP_IDLE;
                psc_pkg::TAP_IDLE:  st_d.tap = i_tms ? psc_pkg::TAP_SELDR
                                                     : psc_pkg::TAP_IDLE;
                psc_pkg::TAP_SELDR: st_d.tap = i_tms ? psc_pkg::TAP_SELIR
                                                     : psc_pkg::TAP_CAPDR;
                psc_pkg::TAP_CAPDR: st_d.tap = i_tms ? psc_pkg::TAP_EX1DR
                                                     : psc_pkg::TAP_SHFDR;
                psc_pkg::TAP_SHFDR: st_d.tap = i_tms ? psc_pkg::TAP_EX1DR
                                                     : psc_pkg::TAP_SHFDR;
                psc_pkg::TAP_EX1DR: st_d.tap = i_tms ? psc_pkg::TAP_UPDDR
                                                     : psc_pkg::TAP_PAUDR;
                psc_pkg::TAP_PAUDR: st_d.tap = i_tms ? psc_pkg::TAP_EX2DR
                                                     : psc_pkg::TAP_PAUDR;
                psc_pkg::TAP_EX2DR: st_d.tap = i_tms ? psc_pkg::TAP_UPDDR
                                                     : psc_pkg::TAP_SHFDR;
                psc_pkg::TAP_UPDDR: st_d.tap = i_tms ? psc_pkg::TAP_SELDR
                                                     : psc_pkg::TAP_IDLE;
                psc_pkg::TAP_SELIR: st_d.tap = i_tms ? psc_pkg::TAP_RESET
                                                     : psc_pkg::TAP_CAPIR;
                psc_pkg::TAP_CAPIR: st_d.tap = i_tms ? psc_pkg::TAP_EX1IR
                                                     : psc_pkg::TAP_SHFIR;
                psc_pkg::TAP_SHFIR: st_d.tap = i_tms ? psc_pkg::TAP_EX1IR
                                                     : psc_pkg::TAP_SHFIR;
                psc_pkg::TAP_EX1IR: st_d.tap = i_tms ? psc_pkg::TAP_UPDIR
                                                     : psc_pkg::TAP_PAUIR;
                psc_pkg::TAP_PAUIR: st_d.tap = i_tms ? psc_pkg::TAP_EX2IR
                                                     : psc_pkg::TAP_PAUIR;
                psc_pkg::TAP_EX2IR: st_d.tap = i_tms ? psc_pkg::TAP_UPDIR
                                                     : psc_pkg::TAP_SHFIR;
                psc_pkg::TAP_UPDIR: st_d.tap = i_tms ? psc_pkg::TAP_SELDR
                                                     : psc_pkg::TAP_IDLE;
            endcase
        end
        if (t_fall) begin
            st_d.tdo = st_q.bypass;
        end

        // Bus writes: address and data in either order
        if (i_axi_awvalid && st_q.awready) begin
            st_d.aw_got  = 1'b1;
            st_d.awready = 1'b0;
            st_d.waddr   = i_axi_awaddr;
        end
        if (i_axi_wvalid && st_q.wready) begin
            st_d.w_got  = 1'b1;
            st_d.wready = 1'b0;
            st_d.wdata  = i_axi_wdata;
            // Strobe kept with its data; its byte 0 bit later gates the control write
            st_d.ctrl_we = i_axi_wstrb[0];
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = psc_pkg::RESP_OKAY;
            if (st_q.waddr == psc_pkg::CTRL_OFS) begin
                if (st_q.ctrl_we) begin
                    st_d.force_sleep = st_q.wdata[psc_pkg::CTRL_SLEEP];
                end
            end else if (st_q.waddr != psc_pkg::STATUS_OFS) begin
                st_d.bresp = psc_pkg::RESP_DEC;
            end
        end
        if (st_q.bvalid && i_axi_bready) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        // Bus reads
        if (i_axi_arvalid && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rresp   = psc_pkg::RESP_OKAY;
            st_d.rdata   = 32'h0;
            if (ra == psc_pkg::CTRL_OFS) begin
                st_d.rdata[psc_pkg::CTRL_SLEEP] = st_q.force_sleep;
            end else if (ra == psc_pkg::STATUS_OFS) begin
                st_d.rdata[psc_pkg::ST_SLEEP] = sleep;
                st_d.rdata[psc_pkg::ST_MODE]  = st_q.mode;
                st_d.rdata[psc_pkg::ST_SUSP]  = ~qual;
                st_d.rdata[psc_pkg::ST_TAP +: 16] = st_q.tap;
            end else begin
                st_d.rresp = psc_pkg::RESP_DEC;
            end
        end
        if (st_q.rvalid && i_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_io_oe       = st_q.io_oe;
    assign o_tdo         = st_q.tdo;
    assign o_axi_awready = st_q.awready;
    assign o_axi_wready  = st_q.wready;
    assign o_axi_bvalid  = st_q.bvalid;
    assign o_axi_bresp   = st_q.bresp;
    assign o_axi_arready = st_q.arready;
    assign o_axi_rvalid  = st_q.rvalid;
    assign o_axi_rdata   = st_q.rdata;
    assign o_axi_rresp   = st_q.rresp;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence rd_issue;
        qual && st_q.s1_vld && !st_q.s1_wr && !sleep
        && !i_output_drive_n;
    endsequence
    sequence wr_data_phase;
        qual && st_q.s1_vld && st_q.s1_wr;
    endsequence

    a_suspend_hold: assert property (
        !qual |=> $stable(st_q.s1_addr) && $stable(st_q.dout)
                  && $stable(o_io_oe))
        else $error("state moved while suspended");
    a_stretch_keeps_sel: assert property (
        !qual && st_q.s1_vld |=> st_q.s1_vld)
        else $error("suspend deselected the device");
    a_write_capture: assert property (
        qual |=> st_q.din == $past(pin_word))
        else $error("data register missed the pins");
    a_read_latency: assert property (
        rd_issue |=> o_io_oe && st_q.dout == $past(rd_word))
        else $error("read data not driven one cycle later");
    a_drive_gated: assert property (
        qual && i_output_drive_n |=> !o_io_oe)
        else $error("drove with output-drive disabled");
    a_write_tristate: assert property (
        wr_data_phase |=> !o_io_oe)
        else $error("drove during write data phase");
    a_burst_order: assert property (
        qual && !sleep && i_ctl.advance_or_load && st_q.mode
        |=> st_q.s1_addr[1:0] == (st_q.base ^ st_q.cnt))
        else $error("interleaved burst address wrong");
    a_tdo_falling: assert property (
        $changed(o_tdo) |-> $past(t_fall))
        else $error("serial out changed off a falling edge");
    a_tap_step: assert property (
        t_rise && i_tms && st_q.tap == psc_pkg::TAP_IDLE
        |=> st_q.tap == psc_pkg::TAP_SELDR ##1
            st_q.tap == psc_pkg::TAP_SELDR || t_rise)
        else $error("TAP did not step on mode select");
    a_sleep_quiet: assert property (
        qual && sleep |=> !st_q.s1_vld ##1 !o_io_oe)
        else $error("operation taken during sleep");
endmodule : psc_sram
`default_nettype wire

// [psc_pkg.sv]
`default_nettype none
package psc_pkg;
    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  STATUS_OFS = 8'h04;
    localparam int          CTRL_SLEEP = 0;
    localparam int          ST_SLEEP   = 0;
    localparam int          ST_MODE    = 1;
    localparam int          ST_SUSP    = 2;
    localparam int          ST_TAP     = 16;
    localparam logic        MODE_RST   = 1'b1;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_DEC   = 2'h3;
    localparam int          LANE_W     = 9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic chip_select_1_n;
        logic chip_select_2;
        logic chip_select_3_n;
        logic write_select_n;
        logic advance_or_load;
    } psc_ctl_t;

    typedef enum logic [15:0] {
        TAP_RESET  = 16'h0001,
        TAP_IDLE   = 16'h0002,
        TAP_SELDR  = 16'h0004,
        TAP_CAPDR  = 16'h0008,
        TAP_SHFDR  = 16'h0010,
        TAP_EX1DR  = 16'h0020,
        TAP_PAUDR  = 16'h0040,
        TAP_EX2DR  = 16'h0080,
        TAP_UPDDR  = 16'h0100,
        TAP_SELIR  = 16'h0200,
        TAP_CAPIR  = 16'h0400,
        TAP_SHFIR  = 16'h0800,
        TAP_EX1IR  = 16'h1000,
        TAP_PAUIR  = 16'h2000,
        TAP_EX2IR  = 16'h4000,
        TAP_UPDIR  = 16'h8000
    } psc_tap_t;
endpackage : psc_pkg
`default_nettype wire

// [psc_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module psc_bus_model (
    input  wire logic         i_sys_clk,             // Clock
    output logic              o_clock_qualifier_n,   // Qualifier
    output logic [18:0]       o_addr,                // Address
    output psc_pkg::psc_ctl_t o_ctl,                 // Controls
    output logic [3:0]        o_byte_write_select_n, // Lane selects
    output logic [35:0]       o_lanes                // Parity, data
);
    logic        drv_q   = 1'b0;
    logic [35:0] wd_q    = 36'h0;
    logic [35:0] noise_q = 36'h0;
    // Released lines toggle, so stale data never reads as valid
    always @(posedge i_sys_clk) noise_q <= ~noise_q;
    assign o_lanes = drv_q ? wd_q : noise_q;
    initial begin
        o_clock_qualifier_n = 1'b0;
        o_addr = 19'h0;
        o_ctl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        o_byte_write_select_n = 4'hf;
    end
    task step(input logic cen_n, sel, we_n, adv,
              input logic [18:0] a, input logic [3:0] bw);
        @(posedge i_sys_clk);
        o_clock_qualifier_n <= cen_n;
        o_ctl <= '{!sel, sel, !sel, we_n, adv};
        o_addr <= a;
        o_byte_write_select_n <= bw;
    endtask : step
    task drive(input logic on, input logic [35:0] d);
        drv_q <= on;
        wd_q <= d;
    endtask : drive
endmodule : psc_bus_model
`default_nettype wire

// [test_pipelined_sram_port_control.sv]
`timescale 1ns/10ps
`default_nettype none
module test_pipelined_sram_port_control;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_output_drive_n = 1'b0;
    logic i_burst_order_strap = 1'b1, i_sleep_request = 1'b0;
    logic i_tck = 1'b0, i_tms = 1'b1, i_tdi = 1'b0;
    logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
    logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
    logic [7:0] i_axi_awaddr = 8'h0, i_axi_araddr = 8'h0;
    logic [31:0] i_axi_wdata = 32'h0;
    logic [3:0] i_axi_wstrb = 4'h0;
    logic i_clock_qualifier_n;
    logic [18:0] i_addr;
    psc_pkg::psc_ctl_t i_ctl;
    logic [3:0] i_byte_write_select_n, o_parity_io_lines;
    logic [35:0] lanes;
    logic [31:0] o_dq, o_axi_rdata, rv;
    logic o_io_oe, o_tdo, o_axi_awready, o_axi_wready, o_axi_bvalid;
    logic o_axi_arready, o_axi_rvalid;
    logic [1:0] o_axi_bresp, o_axi_rresp, rr;
    logic [35:0] mem [int];
    int err_total = 0, n_tests = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    psc_bus_model m (.i_sys_clk, .o_clock_qualifier_n(i_clock_qualifier_n),
        .o_addr(i_addr), .o_ctl(i_ctl), .o_lanes(lanes),
        .o_byte_write_select_n(i_byte_write_select_n));
    psc_sram #(.ADDR_W(19), .LANES(4)) dut (.i_sys_clk, .i_rst_n,
        .i_clock_qualifier_n, .i_addr, .i_ctl, .i_byte_write_select_n,
        .i_dq(lanes[31:0]), .i_parity_io_lines(lanes[35:32]), .o_dq,
        .o_parity_io_lines, .o_io_oe, .i_output_drive_n,
        .i_burst_order_strap, .i_sleep_request, .i_tck, .i_tms, .i_tdi,
        .o_tdo, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
        .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb,
        .o_axi_bvalid, .i_axi_bready, .o_axi_bresp, .i_axi_arvalid,
        .o_axi_arready, .i_axi_araddr, .o_axi_rvalid, .i_axi_rready,
        .o_axi_rdata, .o_axi_rresp);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task check(input logic [35:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task done(input string s);
        $display("test %s finished", s);
    endtask : done
    task do_reset(input logic s);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        i_burst_order_strap <= s;
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
    endtask : do_reset
    task wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] bw);
        m.step(0, 1, 0, 0, a, bw);
        m.step(0, 0, 1, 0, a, bw);
        m.step(0, 0, 1, 0, a, bw);
        m.drive(1, d);
        #1 check(36'(o_io_oe), 36'h0);
        m.step(0, 0, 1, 0, a, 4'hf);
        m.drive(0, d);
        for (int g = 0; g < 4; g++) if (!bw[g]) begin
            mem[a][8*g +: 8] = d[8*g +: 8];
            mem[a][32+g] = d[32+g];
        end
    endtask : wr
    // Beats are judged one cycle after their address edge
    task rd(input logic [18:0] a, input int n, input logic il, ok);
        logic [18:0] ea;
        m.step(0, 1, 1, 0, a, 4'hf);
        for (int k = 0; k <= n; k++) begin
            m.step(0, k < n - 1, 1, k < n - 1, a, 4'hf);
            #1;
            ea = il ? a ^ 19'(k - 1) : {a[18:2], a[1:0] + 2'(k - 1)};
            if (k > 0) check(36'(o_io_oe), 36'(ok));
            if (k > 0 && ok) check({o_parity_io_lines, o_dq}, mem[ea]);
        end
    endtask : rd
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'b111;
        i_axi_awaddr <= a;
        i_axi_wdata <= d;
        i_axi_wstrb <= 4'hf;
        forever begin
            @(posedge i_sys_clk);
            if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 1'b0;
            if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 1'b0;
            if (o_axi_bvalid) begin
                rr = o_axi_bresp;
                i_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr
    task axi_rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        {i_axi_arvalid, i_axi_rready} <= 2'b11;
        i_axi_araddr <= a;
        forever begin
            @(posedge i_sys_clk);
            if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 1'b0;
            if (o_axi_rvalid) begin
                rv = o_axi_rdata;
                rr = o_axi_rresp;
                i_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd
    // Test clock high lasts two system cycles, low at least three, above the sampling floor
    task tap(input logic ms, di);
        @(posedge i_sys_clk);
        i_tms <= ms;
        i_tdi <= di;
        repeat (2) @(posedge i_sys_clk);
        i_tck <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_tck <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask : tap

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        repeat (2) @(posedge i_sys_clk);
        #1 check(36'({o_io_oe, o_tdo, o_axi_awready, o_axi_wready,
                      o_axi_arready, o_axi_bvalid, o_axi_rvalid}), 36'h1c);
        axi_rd(psc_pkg::STATUS_OFS);
        check(36'(rv), 36'({psc_pkg::TAP_RESET, 16'h0002}));
        done("reset");
        for (int k = 0; k < 4; k++)
            wr(19'h40 + 19'(k), 36'h5a5c30f00 ^ {9{4'(k)}}, 4'h0);
        wr(19'h41, 36'hfffffffff, 4'b1010);
        rd(19'h41, 4, 1, 1);
        done("write_burst");
        @(posedge i_sys_clk) i_output_drive_n <= 1'b1;
        rd(19'h40, 1, 1, 0);
        @(posedge i_sys_clk) i_output_drive_n <= 1'b0;
        done("drive_off");
        m.step(0, 1, 1, 0, 19'h42, 4'hf);
        m.step(0, 1, 1, 0, 19'h42, 4'hf);
        for (int j = 0; j < 4; j++) begin
            m.step(1, 0, 1, 0, 19'h42, 4'hf);
            #1 check({o_parity_io_lines, o_dq}, mem[19'h42]);
            check(36'(o_io_oe), 36'h1);
        end
        axi_rd(psc_pkg::STATUS_OFS);
        check(36'(rv[psc_pkg::ST_SUSP]), 36'h1);
        repeat (3) m.step(0, 0, 1, 0, 19'h42, 4'hf);
        #1 check(36'(o_io_oe), 36'h0);
        done("qualifier");
        @(posedge i_sys_clk) i_sleep_request <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd(19'h43, 1, 1, 0);
        @(posedge i_sys_clk) i_sleep_request <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        rd(19'h43, 1, 1, 1);
        done("sleep");
        axi_wr(psc_pkg::CTRL_OFS, 32'h1);
        check(36'(rr), 36'(psc_pkg::RESP_OKAY));
        axi_rd(psc_pkg::STATUS_OFS);
        check(36'(rv[0]), 36'h1);
        rd(19'h40, 1, 1, 0);
        axi_wr(psc_pkg::CTRL_OFS, 32'h0);
        axi_rd(psc_pkg::CTRL_OFS);
        check(36'(rv), 36'h0);
        axi_wr(8'h08, 32'h1);
        check(36'(rr), 36'(psc_pkg::RESP_DEC));
        axi_rd(8'h0c);
        check({rv, 2'b00, rr}, 36'(psc_pkg::RESP_DEC));
        done("registers");
        for (int k = 0; k < 4; k++) tap(k == 1, 0);
        axi_rd(psc_pkg::STATUS_OFS);
        check(36'(rv[31:16]), 36'(psc_pkg::TAP_SHFDR));
        tap(0, 1);
        check(36'(o_tdo), 36'h1);
        tap(0, 0);
        check(36'(o_tdo), 36'h0);
        repeat (5) tap(1, 0);
        axi_rd(psc_pkg::STATUS_OFS);
        check(36'(rv[31:16]), 36'(psc_pkg::TAP_RESET));
        done("test_port");
        do_reset(1'b0);
        rd(19'h41, 4, 0, 1);
        done("linear_burst");
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge i_sys_clk);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : test_pipelined_sram_port_control
`default_nettype wire
